// ===== sim/lcd_common_sva.sv
// checker: port timing of the lcd common pin driver
`timescale 1ns/1ps
`default_nettype none
module lcd_common_sva
(
    input wire logic core_clk,
    input wire logic reset,
    input wire lcd_common_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] gpio_oe,
    input wire logic port_b_pin6_oe,
    input wire logic port_b_pin7_oe,
    input wire logic port_c_pin7_oe,
    input wire logic port_c_pin6_oe,
    input wire logic [3:0] half_bias_en,
    input wire logic common_module_on,
    input wire lcd_common_pkg::bias_current_t bias_current_sel
);
    import lcd_common_pkg::*;
    logic [7:0] shadow_reg;
    logic wr, rd;
    logic [3:0] oe;
    assign wr = reg_req.write && reg_req.addr == LCD_COMMON_CONTROL_OFFSET;
    assign rd = reg_req.read && reg_req.addr == LCD_COMMON_CONTROL_OFFSET;
    assign oe = {port_c_pin6_oe, port_c_pin7_oe, port_b_pin7_oe, port_b_pin6_oe};
    // shadow copy: unmapped writes must never reach it
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
            shadow_reg <= 8'h00;
        else if (wr)
            shadow_reg <= reg_req.wdata;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_module_switch: assert property (wr |-> ##2 common_module_on == $past(reg_req.wdata[4], 2))
        else $error("on/off bit not followed");
    a_bias_code: assert property (wr |-> ##2 bias_current_sel == $past(reg_req.wdata[6:5], 2))
        else $error("bias code not followed");
    a_line_select: assert property (wr |-> ##2 half_bias_en ==
        ($past(reg_req.wdata[3:0], 2) & {4{$past(reg_req.wdata[4], 2)}}))
        else $error("line select wrong");
    a_pad_released: assert property ((half_bias_en & oe) == 4'h0)
        else $error("pad driven during bias");
    a_gpio_dir: assert property (!$past(reset) |-> (oe & ~half_bias_en) == ($past(gpio_oe) & ~half_bias_en))
        else $error("gpio direction lost");
    a_read_back: assert property (rd |=> reg_rdata == $past(shadow_reg))
        else $error("read data wrong");
    a_read_idle: assert property (!rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_setting_hold: assert property (!wr |-> ##2 $stable(half_bias_en) && $stable(bias_current_sel))
        else $error("setting moved without write");
endmodule : lcd_common_sva
`default_nettype wire

// ===== sim/lcd_panel_model.sv
// partner: lcd common electrodes, level seen on each shared pad
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
(
    input wire logic [3:0] pad_out,
    input wire logic [3:0] pad_oe,
    input wire logic [3:0] half_bias,
    output logic [7:0] level
);
    // 2 = half supply, 0/1 = driven, 3 = floating so a stale value never passes
    always_comb
        for (int i = 0; i < 4; i++)
            level[2*i +: 2] = half_bias[i] ? 2'h2 : pad_oe[i] ? {1'b0, pad_out[i]} : 2'h3;
endmodule : lcd_panel_model
`default_nettype wire

// ===== sim/test_lcd_common_pin_driver_ctrl.sv
// testbench: corner and random control words against pad levels
`timescale 1ns/1ps
`default_nettype none
module test_lcd_common_pin_driver_ctrl;
    import lcd_common_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    reg_req_t reg_req = '0;
    logic [7:0] reg_rdata, level, ctl;
    logic [3:0] gpio_out = '0, gpio_oe = '0, pad_out, pad_oe, half_bias_en;
    logic common_module_on;
    bias_current_t bias_current_sel;
    logic [31:0] seed = 32'h6955_4a28;
    int errors = 0, check_count = 0;
    lcd_common_pin_driver_ctrl lcd_common_pin_driver_ctrl_i
    (
        .*,
        .port_b_pin6_out(pad_out[0]),
        .port_b_pin6_oe(pad_oe[0]),
        .port_b_pin7_out(pad_out[1]),
        .port_b_pin7_oe(pad_oe[1]),
        .port_c_pin7_out(pad_out[2]),
        .port_c_pin7_oe(pad_oe[2]),
        .port_c_pin6_out(pad_out[3]),
        .port_c_pin6_oe(pad_oe[3])
    );
    lcd_panel_model lcd_panel_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .half_bias(half_bias_en), .level(level));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // bias only with both enables, otherwise the port path decides
    function automatic logic [7:0] exp_level(logic [7:0] c, logic [3:0] o, logic [3:0] e);
        for (int i = 0; i < 4; i++)
            exp_level[2*i +: 2] = (c[4] && c[i]) ? 2'h2 : e[i] ? {1'b0, o[i]} : 2'h3;
    endfunction : exp_level
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one strobe cycle; read data is looked at just after the following edge
    task automatic bus(logic [3:0] a, logic [7:0] d, logic w);
        @(posedge core_clk);
        reg_req <= '{a, d, w, !w};
        @(posedge core_clk);
        reg_req.write <= 1'b0;
        reg_req.read <= 1'b0;
        #1;
    endtask : bus
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial
        forever #25 core_clk = ~core_clk;
    initial
    begin
        #200000;
        errors++;
        complete_run();
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        bus(4'h0, 8'h00, 1'b0);
        check("reset_value", 8'h00, reg_rdata);
        for (int n = 0; n < 44; n++)
        begin
            seed = lfsr(seed);
            // corners first: all bias, master off, master alone, top code
            ctl = n < 4 ? 8'(32'h7a10_0f1f >> (8 * n)) : seed[7:0] & 8'h7f;
            @(posedge core_clk);
            gpio_out <= seed[11:8];
            gpio_oe <= seed[15:12];
            bus(4'h0, ctl, 1'b1);
            bus(4'h3, ~ctl, 1'b1);
            // unmapped reads must come back as zero, not as the control word
            bus(4'h3, 8'h00, 1'b0);
            check("unmapped_read", 8'h00, reg_rdata);
            bus(4'h0, 8'h00, 1'b0);
            check("read_back", ctl, reg_rdata);
            check("pad_level", exp_level(ctl, seed[11:8], seed[15:12]), level);
            check("bias_on", {5'h0, ctl[6:4]}, {5'h0, bias_current_sel, common_module_on});
        end
        complete_run();
    end
endmodule : test_lcd_common_pin_driver_ctrl
bind lcd_common_pin_driver_ctrl lcd_common_sva lcd_common_sva_i (.*);
`default_nettype wire

// ===== verilog/lcd_common_pin_cell.sv
// one shared pin: gpio path or lcd common half-bias drive
`timescale 1ns/1ps
`default_nettype none
module lcd_common_pin_cell
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic master_enable,
    input wire logic line_select,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic pin_out,
    output logic pin_oe,
    output logic half_bias_en
);
    import lcd_common_pkg::*;

    pin_mode_t mode_reg;
    pin_mode_t mode_next;

    // ------------------------------------------------------------
    // pin function
    // ------------------------------------------------------------
    // common drive needs both enables; else plain gpio
    always_comb
    begin
        if (master_enable && line_select)
        begin
            mode_next = PIN_HALF_BIAS;
        end
        else
        begin
            mode_next = PIN_GPIO;
        end
    end

    // registered copy of the mode; only unused_mode reads it, the pad drive below uses mode_next
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            mode_reg <= PIN_GPIO;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    // ------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------
    // in bias mode the digital driver is off and the analog vdd/2 source
    // owns the pad; the port direction bit is ignored then
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            half_bias_en <= 1'b0;
        end
        else if (mode_next == PIN_HALF_BIAS)
        begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            half_bias_en <= 1'b1;
        end
        else
        begin
            pin_out <= gpio_out;
            pin_oe <= gpio_oe;
            half_bias_en <= 1'b0;
        end
    end

    logic unused_mode;
    assign unused_mode = mode_reg == PIN_HALF_BIAS;
endmodule : lcd_common_pin_cell
`default_nettype wire

// ===== verilog/lcd_common_pin_driver_ctrl.sv
// top: control register and pin muxing of the lcd common line drivers
//
// Function
// - common drive needs master and line enable
// - selected pin driven to half supply
// - otherwise pin stays ordinary gpio
// - common drive ignores port direction register
// - select bits 0..3 map pb6,pb7,pc7,pc6
// - bits 6:5 pick bias current 25..200ua
// - bit 4 switches whole module on/off
`timescale 1ns/1ps
`default_nettype none
module lcd_common_pin_driver_ctrl
(
    input wire logic core_clk,
    input wire logic reset,
    input wire lcd_common_pkg::reg_req_t reg_req,
    output logic [lcd_common_pkg::DATA_WIDTH-1:0] reg_rdata,
    input wire logic [lcd_common_pkg::NUM_LINES-1:0] gpio_out,
    input wire logic [lcd_common_pkg::NUM_LINES-1:0] gpio_oe,
    output logic port_b_pin6_out,
    output logic port_b_pin6_oe,
    output logic port_b_pin7_out,
    output logic port_b_pin7_oe,
    output logic port_c_pin7_out,
    output logic port_c_pin7_oe,
    output logic port_c_pin6_out,
    output logic port_c_pin6_oe,
    output logic [lcd_common_pkg::NUM_LINES-1:0] half_bias_en,
    output logic common_module_on,
    output lcd_common_pkg::bias_current_t bias_current_sel
);
    import lcd_common_pkg::*;

    logic [DATA_WIDTH-1:0] lcd_common_control_reg;
    control_t ctrl;
    logic [NUM_LINES-1:0] line_out;
    logic [NUM_LINES-1:0] line_oe;

    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a);
        hit = (a == LCD_COMMON_CONTROL_OFFSET);
    endfunction : hit

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // all eight bits are stored as written, bit 7 included, since software
    // is expected to keep it clear and the hardware does not police it
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            lcd_common_control_reg <= LCD_COMMON_CONTROL_RESET;
        end
        else if (reg_req.write && hit(reg_req.addr))
        begin
            lcd_common_control_reg <= reg_req.wdata;
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata <= UNMAPPED_READ;
        end
        else if (reg_req.read && hit(reg_req.addr))
        begin
            reg_rdata <= lcd_common_control_reg;
        end
        else
        begin
            reg_rdata <= UNMAPPED_READ;
        end
    end

    assign ctrl = control_t'(lcd_common_control_reg);

    // ------------------------------------------------------------
    // module level outputs
    // ------------------------------------------------------------
    // registered so they line up with the pin mode change
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            common_module_on <= 1'b0;
            bias_current_sel <= BIAS_25UA;
        end
        else
        begin
            common_module_on <= lcd_common_control_reg[MASTER_ENABLE_BIT];
            bias_current_sel <= bias_current_t'(lcd_common_control_reg[BIAS_SEL_HI_BIT:BIAS_SEL_LO_BIT]);
        end
    end

    // ------------------------------------------------------------
    // pin cells
    // ------------------------------------------------------------
    // index n of gpio and half_bias vectors is common line n; waveforms are
    // left to firmware toggling selects and gpio data (no sequencer here)
    for (genvar n = 0; n < NUM_LINES; n++)
    begin : g_line
        lcd_common_pin_cell u_cell
        (
            .core_clk(core_clk),
            .reset(reset),
            .master_enable(ctrl.common_master_enable),
            .line_select(lcd_common_control_reg[LINE_SELECT_LSB + n]),
            .gpio_out(gpio_out[n]),
            .gpio_oe(gpio_oe[n]),
            .pin_out(line_out[n]),
            .pin_oe(line_oe[n]),
            .half_bias_en(half_bias_en[n])
        );
    end

    // line to pad mapping: 0 pb6, 1 pb7, 2 pc7, 3 pc6
    assign port_b_pin6_out = line_out[0];
    assign port_b_pin6_oe = line_oe[0];
    assign port_b_pin7_out = line_out[1];
    assign port_b_pin7_oe = line_oe[1];
    assign port_c_pin7_out = line_out[2];
    assign port_c_pin7_oe = line_oe[2];
    assign port_c_pin6_out = line_out[3];
    assign port_c_pin6_oe = line_oe[3];

    logic unused_ctrl;
    assign unused_ctrl = ctrl.reserved ^ (^ctrl.bias_current) ^ (^ctrl.common_line_select);
endmodule : lcd_common_pin_driver_ctrl
`default_nettype wire

// ===== verilog/lcd_common_pkg.sv
// package: register layout, field positions and encodings of the lcd common pin driver
package lcd_common_pkg;
    localparam int unsigned DATA_WIDTH = 8;
    localparam int unsigned ADDR_WIDTH = 4;
    localparam int unsigned NUM_LINES = 4;
    localparam logic [ADDR_WIDTH-1:0] LCD_COMMON_CONTROL_OFFSET = 4'h0;
    localparam logic [DATA_WIDTH-1:0] LCD_COMMON_CONTROL_RESET = 8'h00;
    localparam int unsigned LINE_SELECT_LSB = 0;
    localparam int unsigned MASTER_ENABLE_BIT = 4;
    localparam int unsigned BIAS_SEL_LO_BIT = 5;
    localparam int unsigned BIAS_SEL_HI_BIT = 6;
    localparam int unsigned RESERVED_BIT = 7;
    localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ = 8'h00;

    // bias current codes
    typedef enum logic [1:0]
    {
        BIAS_25UA = 2'h0,
        BIAS_50UA = 2'h1,
        BIAS_100UA = 2'h2,
        BIAS_200UA = 2'h3
    } bias_current_t;

    // register bus request
    typedef struct packed
    {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic write;
        logic read;
    } reg_req_t;

    // decoded control fields
    typedef struct packed
    {
        logic reserved;
        bias_current_t bias_current;
        logic common_master_enable;
        logic [NUM_LINES-1:0] common_line_select;
    } control_t;

    // state of one pin: plain gpio or half-supply bias drive
    typedef enum logic
    {
        PIN_GPIO,
        PIN_HALF_BIAS
    } pin_mode_t;
endpackage : lcd_common_pkg
